// >>> modem_sync_preamble_config_tb.sv
`timescale 1ns/100ps
`include "mscfg_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module modem_sync_preamble_config_tb;
    import mscfg_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_frame_start, corr_hit, demod_en;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, ev_r;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, bq;
    logic [7:0] samp, offset_estimate;
    logic [4:0] pb;
    logic [1:0] zn;
    mscfg_rx_t rx_in;
    mscfg_ctl_t ctl_out;
    int err_count, checks, i, n;
    assign rx_in = '{ev_r[0], corr_hit, ev_r[1], ev_r[2], demod_en, samp};
    assign tx_frame_start = ev_r[3];
    mscfg_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in, .tx_frame_start, .ctl_out,
        .offset_estimate);
    always #2 aclk = ~aclk;
    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Handshakes are judged at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [13:0] a, input logic [7:0] v, input logic [3:0] s);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            bq = s_axi_bresp;
            @(posedge aclk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
                break;
        end
        if (n == 50)
        begin
            err_count++;
            close_out();
        end
    endtask
    task automatic rd(input logic [13:0] a);
        logic ar, rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (rv)
                break;
        end
        if (n == 50)
        begin
            err_count++;
            close_out();
        end
    endtask
    task automatic pulse(input int k);
        @(posedge aclk);
        ev_r[k] <= 1'b1;
        @(posedge aclk);
        ev_r[k] <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic drv(input logic c, input logic e, input logic [7:0] s);
        @(posedge aclk);
        corr_hit <= c;
        demod_en <= e;
        samp <= s;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask
    initial
    begin
        aclk = 0;
        aresetn = 0;
        s_axi_awvalid = 0;
        s_axi_wvalid = 0;
        s_axi_arvalid = 0;
        s_axi_bready = 1;
        s_axi_rready = 1;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        ev_r = '0;
        corr_hit = 0;
        demod_en = 0;
        samp = '0;
        err_count = 0;
        checks = 0;
        bq = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`MSCFG_ADDR_CONFIG0);
        `CHK(d, 32'h0000_0045);
        `CHK(r, `MSCFG_RESP_OKAY);
        `CHK(ctl_out.preamble_bytes, 5'h04);
        rd(`MSCFG_ADDR_CORR);
        `CHK(d, 32'h0000_000E);
        rd(14'h0200);
        `CHK(r, `MSCFG_RESP_SLVERR);
        `CHK(d, 32'h0000_0000);
        wr(14'h0200, 8'h00, 4'h1);
        `CHK(bq, `MSCFG_RESP_SLVERR);
        wr(`MSCFG_ADDR_CONFIG0, 8'hFF, 4'h0);
        `CHK(bq, `MSCFG_RESP_OKAY);
        rd(`MSCFG_ADDR_CONFIG0);
        `CHK(d, 32'h0000_0045);
        // Upper bits beyond the five threshold bits read back as zero
        wr(`MSCFG_ADDR_CORR, 8'hF4, 4'h1);
        `CHK(bq, `MSCFG_RESP_OKAY);
        rd(`MSCFG_ADDR_CORR);
        `CHK(d, 32'h0000_0014);
        pb = 5'h04;
        for (i = 0; i < 16; i++)
        begin
            wr(`MSCFG_ADDR_CONFIG0, {3'h2, i[3:0], ~i[0]}, 4'h1);
            @(negedge aclk);
            `CHK(ctl_out.preamble_bytes, pb);
            pulse(3);
            pb = {1'b0, i[3:0]} + 5'h02;
            `CHK(ctl_out.preamble_bytes, pb);
            `CHK(ctl_out.tx_extra, ~i[0]);
        end
        zn = 2'h1;
        for (i = 0; i < 4; i++)
        begin
            wr(`MSCFG_ADDR_CONFIG0, {i[1:0], 6'h05}, 4'h1);
            @(negedge aclk);
            `CHK(ctl_out.zeros_needed, zn);
            pulse(0);
            zn = (i == 0) ? 2'h1 : i[1:0];
            `CHK(ctl_out.zeros_needed, zn);
        end
        // Leave zero count 2 in the register before reception starts
        wr(`MSCFG_ADDR_CONFIG0, 8'h85, 4'h1);
        drv(1'b1, 1'b1, 8'h3C);
        pulse(0);
        `CHK(ctl_out.zeros_needed, 2'h2);
        `CHK(ctl_out.sfd_search_ok, 1'b1);
        `CHK(offset_estimate, 8'h00);
        @(negedge aclk);
        `CHK(offset_estimate, 8'h3C);
        pulse(1);
        drv(1'b1, 1'b1, 8'hA5);
        `CHK(offset_estimate, 8'h3C);
        `CHK(ctl_out.sfd_search_ok, 1'b0);
        pulse(2);
        drv(1'b1, 1'b1, 8'hA5);
        `CHK(offset_estimate, 8'hA5);
        wr(`MSCFG_ADDR_CONFIG0, 8'hA5, 4'hF);
        rd(`MSCFG_ADDR_CONFIG0);
        `CHK(d, 32'h0000_00A5);
        pulse(0);
        pulse(1);
        drv(1'b0, 1'b1, 8'h77);
        `CHK(offset_estimate, 8'h77);
        drv(1'b0, 1'b0, 8'h11);
        `CHK(offset_estimate, 8'h77);
        rd(`MSCFG_ADDR_STATUS);
        `CHK(d, 32'h0000_0077);
        close_out();
    end
endmodule

// >>> mscfg_checker.sv
`timescale 1ns/100ps
module mscfg_checker
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire mscfg_pkg::mscfg_rx_t rx_in, // Receiver events
    input wire logic tx_frame_start, // Frame start
    input wire mscfg_pkg::mscfg_ctl_t ctl_out, // Applied controls
    input wire logic [7:0] offset_estimate // Held estimate
);
    import mscfg_pkg::*;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence upd_step;
        ctl_out.offset_update && !rx_in.search_start;
    endsequence
    sequence hold_step;
        !ctl_out.offset_update && !rx_in.search_start;
    endsequence
    a_reset_values: assert property ($rose(aresetn) |-> ctl_out.zeros_needed == 2'h1
        && ctl_out.preamble_bytes == 5'h04 && ctl_out.tx_extra && offset_estimate == 8'h00)
        else $error("bad reset value");
    a_zeros_legal: assert property (ctl_out.zeros_needed != 2'h0)
        else $error("reserved zero count applied");
    a_pre_range: assert property (ctl_out.preamble_bytes inside {[5'h02:5'h11]})
        else $error("preamble count out of range");
    a_sfd_gate: assert property (ctl_out.sfd_search_ok |-> rx_in.corr_hit)
        else $error("search without correlation");
    a_tx_hold: assert property (!tx_frame_start |=> $stable(ctl_out.preamble_bytes)
        && $stable(ctl_out.tx_extra)) else $error("transmit controls changed mid frame");
    a_zero_hold: assert property (!rx_in.search_start |=> $stable(ctl_out.zeros_needed))
        else $error("zero count changed outside search start");
    a_offset_frozen: assert property (hold_step |=> $stable(offset_estimate))
        else $error("estimate moved while locked");
    a_offset_follow: assert property (upd_step |=> offset_estimate == $past(rx_in.offset_sample))
        else $error("estimate did not follow");
    a_update_demod: assert property (ctl_out.offset_update |-> rx_in.demod_en)
        else $error("update with demodulator off");
    a_demod_off: assert property (!rx_in.demod_en |=> !ctl_out.sfd_search_ok)
        else $error("search gate open after demodulator off");
endmodule
bind mscfg_top mscfg_checker chk_u (.aclk, .aresetn, .rx_in, .tx_frame_start, .ctl_out,
    .offset_estimate);

// >>> mscfg_pkg.sv
package mscfg_pkg;
    typedef struct packed {
        logic [1:0] zeros;
        logic avg_cont;
        logic [3:0] pre_len;
        logic tx_extra;
    } mscfg_config_t;

    typedef struct packed {
        logic search_start;
        logic corr_hit;
        logic sync_found;
        logic frame_end;
        logic demod_en;
        logic [7:0] offset_sample;
    } mscfg_rx_t;

    typedef struct packed {
        logic [1:0] zeros_needed;
        logic sfd_search_ok;
        logic offset_update;
        logic tx_extra;
        logic [4:0] preamble_bytes;
    } mscfg_ctl_t;

    typedef enum logic [1:0] {
        MSCFG_RX_IDLE,
        MSCFG_RX_SEARCH,
        MSCFG_RX_FRAME
    } mscfg_rx_state_t;
endpackage

// >>> mscfg_regs.svh
`ifndef MSCFG_REGS_SVH
`define MSCFG_REGS_SVH
// Register indices as printed; byte address is four times the index
`define MSCFG_IDX_CONFIG0 12'h046
`define MSCFG_IDX_CORR 12'h047
`define MSCFG_IDX_STATUS 12'h049
`define MSCFG_ADDR_CONFIG0 14'h0118
`define MSCFG_ADDR_CORR 14'h011C
`define MSCFG_ADDR_STATUS 14'h0124
`define MSCFG_CONFIG0_RESET 8'h45
`define MSCFG_CORR_RESET 5'h0E
`define MSCFG_ZEROS_MSB 7
`define MSCFG_ZEROS_LSB 6
`define MSCFG_AVG_BIT 5
`define MSCFG_PRE_MSB 4
`define MSCFG_PRE_LSB 1
`define MSCFG_TXF_BIT 0
`define MSCFG_PRE_BIAS 5'h02
`define MSCFG_ZEROS_RSVD 2'h0
`define MSCFG_RESP_OKAY 2'h0
`define MSCFG_RESP_SLVERR 2'h2
`endif

// >>> mscfg_top.sv
`timescale 1ns/100ps
`include "mscfg_regs.svh"

module mscfg_top
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [13:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [13:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire mscfg_pkg::mscfg_rx_t rx_in, // Demodulator events, same clock
    input wire logic tx_frame_start, // Pulse: transmit frame begins
    output mscfg_pkg::mscfg_ctl_t ctl_out, // Applied modem controls
    output logic [7:0] offset_estimate // Held frequency offset estimate
);
    import mscfg_pkg::*;

    logic [7:0] config0_r;
    logic [4:0] corr_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [13:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    mscfg_rx_state_t rx_state_r;
    mscfg_rx_state_t rx_state_nxt;
    logic [1:0] zeros_r;
    logic avg_r;
    logic [3:0] pre_r;
    logic txf_r;
    logic [7:0] offset_r;
    logic [7:0] offset_nxt;

    // Write side: accept address and data independently, respond once both held
    wire aw_take = s_axi_awvalid && !aw_hold_r && !bvalid_r;
    wire w_take = s_axi_wvalid && !w_hold_r && !bvalid_r;
    wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    wire wr_cfg = wr_fire && awaddr_r == `MSCFG_ADDR_CONFIG0;
    wire wr_corr = wr_fire && awaddr_r == `MSCFG_ADDR_CORR;
    wire wr_hit = wr_cfg || wr_corr;
    wire [7:0] cfg_merged = wstrb_r[0] ? wdata_r[7:0] : config0_r;
    wire [4:0] corr_merged = wstrb_r[0] ? wdata_r[4:0] : corr_r;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 14'h0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `MSCFG_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `MSCFG_RESP_OKAY : `MSCFG_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // Software-visible registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            config0_r <= `MSCFG_CONFIG0_RESET;
            corr_r <= `MSCFG_CORR_RESET;
        end
        else
        begin
            if (wr_cfg)
                config0_r <= cfg_merged;
            if (wr_corr)
                corr_r <= corr_merged;
        end
    end

    // Read side: one read in flight, answered the cycle after the address
    wire ar_take = s_axi_arvalid && !rvalid_r;
    wire rd_cfg = s_axi_araddr == `MSCFG_ADDR_CONFIG0;
    wire rd_corr = s_axi_araddr == `MSCFG_ADDR_CORR;
    wire rd_stat = s_axi_araddr == `MSCFG_ADDR_STATUS;
    wire [31:0] rd_word = rd_cfg ? {24'h00_0000, config0_r} :
                          rd_corr ? {27'h000_0000, corr_r} :
                          rd_stat ? {24'h00_0000, offset_r} : 32'h0000_0000;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `MSCFG_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (rd_cfg || rd_corr || rd_stat) ? `MSCFG_RESP_OKAY
                                                     : `MSCFG_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Receive framing: idle, searching for sync, inside a frame
    always_comb
    begin
        rx_state_nxt = rx_state_r;
        unique case (rx_state_r)
            MSCFG_RX_IDLE:
                if (rx_in.search_start)
                    rx_state_nxt = MSCFG_RX_SEARCH;
            MSCFG_RX_SEARCH:
                if (rx_in.sync_found)
                    rx_state_nxt = MSCFG_RX_FRAME;
            MSCFG_RX_FRAME:
                if (rx_in.frame_end)
                    rx_state_nxt = MSCFG_RX_IDLE;
        endcase
        if (!rx_in.demod_en)
            rx_state_nxt = MSCFG_RX_IDLE;
    end

    // apply at boundaries: receive fields on search start, shadowed mid-frame
    wire rx_apply = rx_in.search_start && rx_state_r != MSCFG_RX_FRAME;
    wire offset_open = avg_r ? rx_in.demod_en : (rx_state_r != MSCFG_RX_FRAME);
    // restart calibration when a new search begins in locked mode
    wire offset_restart = rx_apply && !config0_r[`MSCFG_AVG_BIT];

    always_comb
    begin
        offset_nxt = offset_r;
        if (offset_restart)
            offset_nxt = 8'h00;
        else if (offset_open && rx_in.demod_en)
            offset_nxt = rx_in.offset_sample;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_state_r <= MSCFG_RX_IDLE;
            zeros_r <= 2'(`MSCFG_CONFIG0_RESET >> `MSCFG_ZEROS_LSB);
            avg_r <= 1'(`MSCFG_CONFIG0_RESET >> `MSCFG_AVG_BIT);
            pre_r <= 4'(`MSCFG_CONFIG0_RESET >> `MSCFG_PRE_LSB);
            txf_r <= 1'(`MSCFG_CONFIG0_RESET >> `MSCFG_TXF_BIT);
            offset_r <= 8'h00;
        end
        else
        begin
            rx_state_r <= rx_state_nxt;
            offset_r <= offset_nxt;
            if (rx_apply)
            begin
                zeros_r <= config0_r[`MSCFG_ZEROS_MSB:`MSCFG_ZEROS_LSB];
                avg_r <= config0_r[`MSCFG_AVG_BIT];
            end
            // transmit fields taken at frame start
            if (tx_frame_start)
            begin
                pre_r <= config0_r[`MSCFG_PRE_MSB:`MSCFG_PRE_LSB];
                txf_r <= config0_r[`MSCFG_TXF_BIT];
            end
        end
    end

    // zero count; reserved code kept as one zero so search never runs unchecked
    assign ctl_out.zeros_needed = (zeros_r == `MSCFG_ZEROS_RSVD) ? 2'h1 : zeros_r;
    // one correlation hit gates the start-of-frame search
    assign ctl_out.sfd_search_ok = rx_state_r == MSCFG_RX_SEARCH && rx_in.corr_hit;
    assign ctl_out.offset_update = offset_open && rx_in.demod_en;
    assign ctl_out.tx_extra = txf_r;
    assign ctl_out.preamble_bytes = {1'b0, pre_r} + `MSCFG_PRE_BIAS;
    assign offset_estimate = offset_r;
endmodule
